// ===== hw/ivp_pkg.sv
package ivp_pkg;
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h01;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control field positions
  localparam int CHANGE_EN_BIT = 0;
  localparam int SELECT_BIT = 1;
  localparam int IRQ2_EN_BIT = 5;
  localparam int IRQ0_EN_BIT = 6;
  localparam int IRQ1_EN_BIT = 7;
  localparam logic [7:0] CTRL_RW_MASK = 8'he3;
  // Unlock window and post-write hold, in cycles
  localparam int UNLOCK_CYCLES = 4;
  localparam int POST_WRITE_CYCLES = 1;
  // Vector table placement, word addresses
  localparam logic [15:0] APP_VECTOR_BASE = 16'h0002;
  localparam logic [15:0] VECTOR_STEP = 16'h0002;
  localparam logic [15:0] FLASH_RESET_ADDR = 16'h0000;
  localparam logic [15:0] BOOT_BASE_2K = 16'h1c00;
  localparam logic [15:0] BOOT_BASE_1K = 16'h1e00;
  localparam logic [15:0] BOOT_BASE_512 = 16'h1f00;
  localparam logic [15:0] BOOT_BASE_256 = 16'h1f80;
  // Fuse polarity: 1 unprogrammed, 0 programmed
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic [1:0] BOOT_SIZE_2K = 2'b00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPEN = 2'b01,
    ST_HOLD = 2'b10
  } unlock_state_t;

  function automatic logic [15:0] boot_base(input logic [1:0] sz);
    case (sz)
      2'b00: boot_base = BOOT_BASE_2K;
      2'b01: boot_base = BOOT_BASE_1K;
      2'b10: boot_base = BOOT_BASE_512;
      default: boot_base = BOOT_BASE_256;
    endcase
  endfunction
endpackage

// ===== hw/vector_base_if.sv
`timescale 1ns/1ps
interface vector_base_if;
  logic [1:0] bootSize;
  logic bootResetFuse;
  logic vectorSelect;
  logic [15:0] vectorBase;
  logic [15:0] resetAddr;
  modport calc (input bootSize, bootResetFuse, vectorSelect,
                output vectorBase, resetAddr);
  modport user (output bootSize, bootResetFuse, vectorSelect,
                input vectorBase, resetAddr);
endinterface

// ===== hw/vector_base_calc.sv
`timescale 1ns/1ps
module vector_base_calc
  import ivp_pkg::*;
(
  vector_base_if.calc vb
);
  logic [15:0] bootStart;
  assign bootStart = boot_base(vb.bootSize);
  // Vector table origin
  assign vb.vectorBase = vb.vectorSelect ?
    16'(bootStart + VECTOR_STEP) : APP_VECTOR_BASE;
  // Reset origin from fuse polarity
  assign vb.resetAddr = (vb.bootResetFuse == FUSE_PROGRAMMED) ?
    bootStart : FLASH_RESET_ADDR;
endmodule

// ===== hw/interrupt_vector_placement.sv
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
//
// Function
// - Select clear: vectors start at flash start.
// - Select set: vectors start at boot section, base set by size fuses.
// - Select changes only via unlock write, then select write within 4 cycles.
// - Change enable self-clears after four cycles or on select write.
// - Interrupts blocked from unlock until instruction after select write.
// - Without select write, blocking lasts exactly four cycles.
// - Blocking never alters the global interrupt enable flag.
// - Boot vectors plus app lock: block interrupts while in app section.
// - App vectors plus boot lock: block interrupts while in boot section.
// - 2K boot, fuse unprogrammed, select set: reset 0, vectors 1c02.
// - 2K boot, fuse programmed: reset 1c00; select clear vectors 002.
// - Boot reset fuse: 1 unprogrammed, 0 programmed.
module interrupt_vector_placement
  import ivp_pkg::*;
#(
  parameter int UNLOCK_LEN = UNLOCK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Fuses and lock bits
  input wire logic bootResetFuse,
  input wire logic [1:0] bootSizeFuses,
  input wire logic appSectionLockBit,
  input wire logic bootSectionLockBit,
  // CPU context
  input wire logic globalIrqEnable,
  input wire logic executingBoot,
  // Results
  output logic irqAllowed,
  output logic [15:0] vectorBase,
  output logic [15:0] resetAddr,
  output logic vectorSelect,
  output logic [2:0] extIrqEnable
);

  // Window counter is three bits wide
  if (UNLOCK_LEN < 1 || UNLOCK_LEN > 7) begin
    $error("UNLOCK_LEN must be 1..7");
  end

  typedef struct packed {
    unlock_state_t state;
    logic [2:0] count;
    logic changeEnable;
    logic select;
    logic [2:0] extEn;
    logic [7:0] rdata;
    logic irqOk;
    logic [15:0] vecBase;
    logic [15:0] rstAddr;
  } state_t;

  state_t cur_ff;
  state_t nxt_s;

  vector_base_if vb ();
  vector_base_calc u_calc (
    .vb(vb)
  );
  assign vb.bootSize = bootSizeFuses;
  assign vb.bootResetFuse = bootResetFuse;
  assign vb.vectorSelect = nxt_s.select;

  function automatic logic [7:0] ctrl_view(input state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[CHANGE_EN_BIT] = s.changeEnable;
    v[SELECT_BIT] = s.select;
    v[IRQ2_EN_BIT] = s.extEn[2];
    v[IRQ0_EN_BIT] = s.extEn[0];
    v[IRQ1_EN_BIT] = s.extEn[1];
    ctrl_view = v & CTRL_RW_MASK;
  endfunction

  logic ctrlWr;
  logic sectionBlock;
  logic unlockBlock;

  always_comb begin
    nxt_s = cur_ff;
    ctrlWr = regWr && (regAddr == CTRL_OFFSET);
    nxt_s.rdata = 8'h00;

    // Unlock timer and window
    case (cur_ff.state)
      ST_IDLE: begin
      end
      ST_OPEN: begin
        if (cur_ff.count == 3'(UNLOCK_LEN - 1)) begin
          nxt_s.state = ST_IDLE;
          nxt_s.changeEnable = 1'b0;
          nxt_s.count = 3'd0;
        end else begin
          nxt_s.count = 3'(cur_ff.count + 3'd1);
        end
      end
      ST_HOLD: begin
        nxt_s.state = ST_IDLE;
        nxt_s.count = 3'd0;
      end
      default: begin
        nxt_s.state = ST_IDLE;
        nxt_s.count = 3'd0;
      end
    endcase

    if (ctrlWr) begin
      nxt_s.extEn[2] = regWdata[IRQ2_EN_BIT];
      nxt_s.extEn[0] = regWdata[IRQ0_EN_BIT];
      nxt_s.extEn[1] = regWdata[IRQ1_EN_BIT];
      if (cur_ff.state == ST_OPEN && !regWdata[CHANGE_EN_BIT]) begin
        nxt_s.select = regWdata[SELECT_BIT];
        nxt_s.changeEnable = 1'b0;
        nxt_s.state = ST_HOLD;
        nxt_s.count = 3'd0;
      end else if (regWdata[CHANGE_EN_BIT]) begin
        nxt_s.changeEnable = 1'b1;
        nxt_s.state = ST_OPEN;
        nxt_s.count = 3'd0;
      end
    end

    if (regRd) begin
      if (regAddr == CTRL_OFFSET) begin
        nxt_s.rdata = ctrl_view(cur_ff);
      end else if (regAddr == STATUS_OFFSET) begin
        nxt_s.rdata = {5'h00, cur_ff.irqOk, cur_ff.state};
      end
    end

    // Section-based blocking
    sectionBlock = (nxt_s.select && appSectionLockBit == FUSE_PROGRAMMED
                    && !executingBoot)
                || (!nxt_s.select && bootSectionLockBit == FUSE_PROGRAMMED
                    && executingBoot);
    unlockBlock = (nxt_s.state != ST_IDLE);
    // Global enable only gates here, never written
    nxt_s.irqOk = globalIrqEnable && !unlockBlock && !sectionBlock;
    nxt_s.vecBase = vb.vectorBase;
    nxt_s.rstAddr = vb.resetAddr;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_s;
    end
  end

  assign regRdata = cur_ff.rdata;
  assign irqAllowed = cur_ff.irqOk;
  assign vectorBase = cur_ff.vecBase;
  assign resetAddr = cur_ff.rstAddr;
  assign vectorSelect = cur_ff.select;
  assign extIrqEnable = cur_ff.extEn;
endmodule

// ===== dv/interrupt_vector_placement_asserts.sv
`timescale 1ns/1ps
module interrupt_vector_placement_asserts
  import ivp_pkg::*;
(
  // Clock, reset, register port
  input wire logic sys_clk, resetn, regWr, regRd,
  input wire logic [7:0] regAddr, regWdata, regRdata,
  // Fuses and context
  input wire logic bootResetFuse, executingBoot, globalIrqEnable,
  input wire logic appSectionLockBit, bootSectionLockBit,
  input wire logic [1:0] bootSizeFuses,
  // Results
  input wire logic irqAllowed, vectorSelect,
  input wire logic [15:0] vectorBase, resetAddr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire ctl = regWr && regAddr == CTRL_OFFSET;
  wire appLk = vectorSelect && !appSectionLockBit && !executingBoot;
  wire bootLk = !vectorSelect && !bootSectionLockBit && executingBoot;
  wire sz0 = bootSizeFuses == 2'b00;
  a_unlock_blocks: assert property (ctl && regWdata[0] |=> !irqAllowed)
    else $error("unlock did not block");
  a_select_guard: assert property ($changed(vectorSelect) |-> $past(ctl))
    else $error("select changed unasked");
  a_rsvd_zero: assert property (regRd && !regAddr |=> !regRdata[4:2])
    else $error("reserved bits set");
  a_app_base: assert property ($past(resetn) && !vectorSelect |->
    vectorBase == APP_VECTOR_BASE) else $error("app base wrong");
  a_boot_base: assert property ($past(resetn) && sz0 && $stable(sz0)
    && vectorSelect |-> vectorBase == 16'h1c02) else $error("boot base");
  a_reset_addr: assert property ($past(resetn) && sz0 && $stable(sz0) &&
    $stable(bootResetFuse) |-> resetAddr == (bootResetFuse ? 16'h0000 :
    16'h1c00)) else $error("reset address wrong");
  a_lock_app: assert property ($past(appLk) |-> !irqAllowed)
    else $error("app lock ignored");
  a_lock_boot: assert property ($past(bootLk) |-> !irqAllowed)
    else $error("boot lock ignored");
  a_gie_gates: assert property (!globalIrqEnable |=> !irqAllowed)
    else $error("global enable ignored");
endmodule
bind interrupt_vector_placement interrupt_vector_placement_asserts chk (.*);

// ===== dv/test_interrupt_vector_placement.sv
`timescale 1ns/1ps
module test_interrupt_vector_placement;
  import ivp_pkg::*;
  logic sys_clk, resetn, regWr, regRd, rdQ, bootResetFuse, irqAllowed;
  logic appSectionLockBit, bootSectionLockBit, globalIrqEnable;
  logic executingBoot, vectorSelect;
  logic [7:0] regAddr, regWdata, regRdata, d;
  logic [7:0] exp[$];
  logic [1:0] bootSizeFuses;
  logic [2:0] extIrqEnable;
  logic [15:0] vectorBase, resetAddr, base;
  int num_errors, comparisons;
  int seed = 32'h2402;
  interrupt_vector_placement DUT (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task cmp(input string n, input logic [15:0] e, v);
    comparisons++;
    if (v !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask
  task op(input logic [7:0] a, v, input logic [1:0] s);
    @(posedge sys_clk);
    {regAddr, regWdata, regWr, regRd} <= {a, v, s};
    if (s[0]) exp.push_back(v);
  endtask
  task idle(input int n);
    repeat (n) op(8'h00, 8'h00, 2'b00);
    #1;
  endtask
  task sel(input logic v);
    op(CTRL_OFFSET, 8'h01, 2'b10);
    op(CTRL_OFFSET, {6'h00, v, 1'b0}, 2'b10);
    idle(3);
  endtask
  task results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    rdQ <= regRd;
    if (rdQ) cmp("rdata", exp.pop_front(), regRdata);
  end
  initial begin
    #20000;
    num_errors++;
    results();
  end
  initial begin
    {resetn, regWr, regRd, regAddr, regWdata} = '0;
    {bootResetFuse, bootSizeFuses, appSectionLockBit} = 4'b1001;
    {bootSectionLockBit, globalIrqEnable, executingBoot} = 3'b111;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    d = 8'($random(seed));
    op(CTRL_OFFSET, CTRL_RESET, 2'b01);
    op(8'h7f, 8'h00, 2'b01);
    op(CTRL_OFFSET, {d[7:2], 2'b10}, 2'b10);
    op(CTRL_OFFSET, {d[7:5], 5'h00}, 2'b01);
    idle(2);
    cmp("ext", {d[5], d[7], d[6]}, extIrqEnable);
    cmp("sel", 1'b0, vectorSelect);
    $display("register test end");
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      {bootSizeFuses, bootResetFuse} <= {s[1:0], s[0]};
      base = 16'h2000 - (16'h0400 >> s);
      sel(1'b1);
      cmp("vbase", base + VECTOR_STEP, vectorBase);
      cmp("raddr", s[0] ? 16'h0000 : base, resetAddr);
      sel(1'b0);
      cmp("vbase", APP_VECTOR_BASE, vectorBase);
    end
    $display("placement test end");
    op(CTRL_OFFSET, 8'h01, 2'b10);
    op(STATUS_OFFSET, 8'h01, 2'b01);
    idle(1);
    cmp("irq", 1'b0, irqAllowed);
    idle(2);
    cmp("irq", 1'b0, irqAllowed);
    idle(1);
    cmp("irq", 1'b1, irqAllowed);
    op(CTRL_OFFSET, 8'h02, 2'b10);
    idle(2);
    cmp("sel", 1'b0, vectorSelect);
    $display("window test end");
    sel(1'b1);
    @(posedge sys_clk);
    {appSectionLockBit, executingBoot} <= 2'b00;
    idle(2);
    cmp("irq", 1'b0, irqAllowed);
    @(posedge sys_clk);
    executingBoot <= 1'b1;
    idle(2);
    cmp("irq", 1'b1, irqAllowed);
    sel(1'b0);
    @(posedge sys_clk);
    {appSectionLockBit, bootSectionLockBit} <= 2'b10;
    idle(2);
    cmp("irq", 1'b0, irqAllowed);
    @(posedge sys_clk);
    {appSectionLockBit, bootSectionLockBit, globalIrqEnable} <= 3'b110;
    idle(2);
    cmp("irq", 1'b0, irqAllowed);
    op(CTRL_OFFSET, 8'h00, 2'b01);
    idle(2);
    $display("lock test end");
    results();
  end
endmodule
